// file: logic/comp_pkg.sv
// shared constants for the dual comparator control block
package comp_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 8;
  localparam int          NUM_COMP        = 2;
  // register byte addresses
  localparam logic [7:0]  OFF_CTRL_ONE    = 8'h00;
  localparam logic [7:0]  OFF_CTRL_TWO    = 8'h04;
  localparam logic [7:0]  OFF_SHARED      = 8'h08;
  localparam logic [7:0]  OFF_FLAGS       = 8'h0C;
  localparam logic [7:0]  OFF_ANALOG_SEL  = 8'h10;
  localparam logic [7:0]  OFF_PORT_READ   = 8'h14;
  // control register fields
  localparam int          B_ENABLE        = 7;
  localparam int          B_RESULT        = 6;
  localparam int          B_PIN_DRIVE     = 5;
  localparam int          B_INVERT        = 4;
  localparam int          B_SPEED         = 3;
  localparam int          B_REF_SEL       = 2;
  localparam int          B_CHAN_HI       = 1;
  localparam int          B_CHAN_LO       = 0;
  // shared register fields, comparator one first
  localparam int          B_MIRROR_ONE    = 7;
  localparam int          B_MIRROR_TWO    = 6;
  localparam int          B_RSEL_ONE      = 5;
  localparam int          B_RSEL_TWO      = 4;
  localparam int          B_HYS_ONE       = 3;
  localparam int          B_HYS_TWO       = 2;
  localparam int          B_SYNC_ONE      = 1;
  localparam int          B_SYNC_TWO      = 0;
  // reset values
  localparam logic [7:0]  RST_CTRL        = 8'h08;
  localparam logic [7:0]  RST_SHARED      = 8'h00;
  localparam logic [7:0]  RST_ANALOG_SEL  = 8'hFF;
  // bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_DECERR     = 2'b11;
endpackage : comp_pkg

// file: logic/comp_ch_if.sv
// link between the register core and one comparator channel
`timescale 1ns/10ps
`default_nettype none
interface comp_ch_if;
  logic enable;       // comparator on
  logic invert;       // output polarity
  logic sync_en;      // latch on timer clock falling edge
  logic raw_above;    // analog decision, noninverting above inverting
  logic access;       // control register read or write, one cycle
  logic result;       // final output bit
  logic change;       // one-cycle pulse on new mismatch
  modport core (output enable, invert, sync_en, raw_above, access,
                input result, change);
  modport chan (input enable, invert, sync_en, raw_above, access,
                output result, change);
endinterface : comp_ch_if
`default_nettype wire

// file: logic/comp_channel.sv
// one comparator: polarity, timer sync and change detection
`timescale 1ns/10ps
`default_nettype none
module comp_channel
  import comp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic timer_fall,
  comp_ch_if.chan   ch
);
  logic decided;
  logic result_r;
  logic stored_r;
  logic mismatch_q_r;
  logic mismatch;

  // when off, the output level is the polarity bit, so software can
  // preset the mismatch latch before turning the comparator on
  assign decided = ch.enable ? (ch.raw_above ^ ch.invert)
                             : ch.invert;

  // output latch: sampled every cycle, or only on timer falling edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= 1'b0;
    end else if (!ch.sync_en || timer_fall) begin
      result_r <= decided;
    end
  end

  // stored copy refreshed by any access to the own control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stored_r <= 1'b0;
    end else if (ch.access) begin
      stored_r <= result_r;
    end
  end

  // edge of the mismatch, not its level, raises the flag
  assign mismatch = stored_r ^ result_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mismatch_q_r <= 1'b0;
    end else begin
      mismatch_q_r <= mismatch;
    end
  end

  assign ch.result = result_r;
  assign ch.change = mismatch & ~mismatch_q_r;
endmodule : comp_channel
`default_nettype wire

// file: logic/comp_port_read.sv
// port read path that hides pins set as analog inputs
`timescale 1ns/10ps
`default_nettype none
module comp_port_read
  import comp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [REG_W-1:0] pin_level,
  input  wire logic [REG_W-1:0] analog_sel,
  output logic      [REG_W-1:0] port_value
);
  // registered so the bus sees a stable sample, not a live pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_value <= '0;
    end else begin
      port_value <= pin_level & ~analog_sel;
    end
  end
endmodule : comp_port_read
`default_nettype wire

// file: logic/comp_ctrl_top.sv
// register bank and pin logic for two analog comparators
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module comp_ctrl_top
  import comp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // analog core and pins
  input  wire logic [1:0]        comp_raw_above,
  input  wire logic [1:0]        pin_direction_control,
  input  wire logic              timer_one_clock,
  input  wire logic [REG_W-1:0]  port_pin_level,
  output logic [1:0]             comp_enable,
  output logic [1:0]             comp_speed_select,
  output logic [1:0]             comp_ref_select,
  output logic [1:0]             comp_channel_select_one,
  output logic [1:0]             comp_channel_select_two,
  output logic [1:0]             ref_source_select,
  output logic [1:0]             hysteresis_enable,
  output logic [1:0]             comp_pin_out,
  output logic [1:0]             comp_pin_oe,
  output logic [1:0]             comp_change_flag,
  output logic                   timer_one_tick
);
  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [REG_W-1:0]  ctrl_r [NUM_COMP];
  logic [REG_W-1:0]  shared_r;
  logic [REG_W-1:0]  analog_sel_r;
  logic [1:0]        flag_r;
  logic [REG_W-1:0]  port_value;
  logic [ADDR_W-1:0] awaddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0]        wstrb_r;
  logic              aw_full_r;
  logic              w_full_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic              tclk_q_r;
  logic              timer_fall;
  logic              wr_go;
  logic              rd_go;
  logic [1:0]        result;
  logic [1:0]        change;
  logic [1:0]        ctrl_access;
  logic [REG_W-1:0]  rd_byte;
  comp_ch_if         ch_if [NUM_COMP] ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and write paths
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    if (a == OFF_CTRL_ONE || a == OFF_CTRL_TWO) begin
      return 1'b1;
    end else if (a == OFF_SHARED || a == OFF_FLAGS) begin
      return 1'b1;
    end else if (a == OFF_ANALOG_SEL || a == OFF_PORT_READ) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : is_mapped

  // which control register, if any, an address hits
  function automatic logic [1:0] ctrl_hit(input logic [ADDR_W-1:0] a);
    if (a == OFF_CTRL_ONE) begin
      return 2'b01;
    end else if (a == OFF_CTRL_TWO) begin
      return 2'b10;
    end else begin
      return 2'b00;
    end
  endfunction : ctrl_hit

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready  = !w_full_r && !bvalid_r;
  assign wr_go         = aw_full_r && w_full_r && !bvalid_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_full_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_r <= 1'b0;
    end
  end

  // response held until the master takes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // register writes; only the low byte lane carries data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r[0] <= RST_CTRL;
      ctrl_r[1] <= RST_CTRL;
    end else if (wr_go && wstrb_r[0]) begin
      if (awaddr_r == OFF_CTRL_ONE) begin
        ctrl_r[0] <= wdata_r[REG_W-1:0];
      end else if (awaddr_r == OFF_CTRL_TWO) begin
        ctrl_r[1] <= wdata_r[REG_W-1:0];
      end
    end
  end

  // mirror bits are written into shared_r but never read back; reads take them live
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_r     <= RST_SHARED;
      analog_sel_r <= RST_ANALOG_SEL;
    end else if (wr_go && wstrb_r[0]) begin
      if (awaddr_r == OFF_SHARED) begin
        shared_r <= wdata_r[REG_W-1:0];
      end else if (awaddr_r == OFF_ANALOG_SEL) begin
        analog_sel_r <= wdata_r[REG_W-1:0];
      end
    end
  end

  // change flags: software may write 0 or 1; a change in the same cycle
  // as the clearing write still sets the flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 2'b00;
    end else if (wr_go && wstrb_r[0] && awaddr_r == OFF_FLAGS) begin
      flag_r <= wdata_r[1:0] | change;
    end else begin
      flag_r <= flag_r | change;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, data registered
  assign rd_go         = s_axi_arvalid && !rvalid_r;
  assign s_axi_arready = !rvalid_r;

  // read byte; the result bit is overlaid from the live channel output
  always_comb begin
    rd_byte = '0;
    if (s_axi_araddr == OFF_CTRL_ONE) begin
      rd_byte           = ctrl_r[0];
      rd_byte[B_RESULT] = result[0];
    end else if (s_axi_araddr == OFF_CTRL_TWO) begin
      rd_byte           = ctrl_r[1];
      rd_byte[B_RESULT] = result[1];
    end else if (s_axi_araddr == OFF_SHARED) begin
      rd_byte               = shared_r;
      rd_byte[B_MIRROR_ONE] = result[0];
      rd_byte[B_MIRROR_TWO] = result[1];
    end else if (s_axi_araddr == OFF_FLAGS) begin
      rd_byte[1:0] = flag_r;
    end else if (s_axi_araddr == OFF_ANALOG_SEL) begin
      rd_byte = analog_sel_r;
    end else if (s_axi_araddr == OFF_PORT_READ) begin
      rd_byte = port_value;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
      rresp_r  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // only the own control register refreshes the stored copy; the shared
  // mirror read is left out on purpose
  assign ctrl_access = (rd_go ? ctrl_hit(s_axi_araddr) : 2'b00)
                     | (wr_go ? ctrl_hit(awaddr_r) : 2'b00);

  ////////////////////////////////////////////////////////////////////////////
  // timer clock edges, sampled as an ordinary input
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tclk_q_r <= 1'b0;
    end else begin
      tclk_q_r <= timer_one_clock;
    end
  end

  // rise counts the timer, fall latches the outputs, so a gated timer
  // never sees its gate move on its own counting edge
  assign timer_fall     = tclk_q_r & ~timer_one_clock;
  assign timer_one_tick = ~tclk_q_r & timer_one_clock;

  ////////////////////////////////////////////////////////////////////////////
  // comparator channels
  for (genvar i = 0; i < NUM_COMP; i++) begin : g_ch
    localparam int SYNC_BIT = (i == 0) ? B_SYNC_ONE : B_SYNC_TWO;
    localparam int RSEL_BIT = (i == 0) ? B_RSEL_ONE : B_RSEL_TWO;
    localparam int HYS_BIT  = (i == 0) ? B_HYS_ONE  : B_HYS_TWO;

    assign ch_if[i].enable    = ctrl_r[i][B_ENABLE];
    assign ch_if[i].invert    = ctrl_r[i][B_INVERT];
    assign ch_if[i].sync_en   = shared_r[SYNC_BIT];
    assign ch_if[i].raw_above = comp_raw_above[i];
    assign ch_if[i].access    = ctrl_access[i];
    assign result[i]          = ch_if[i].result;
    assign change[i]          = ch_if[i].change;

    comp_channel u_ch (
      .clk        (clk),
      .rst_b      (rst_b),
      .timer_fall (timer_fall),
      .ch         (ch_if[i])
    );

    // analog steering
    assign comp_enable[i]       = ctrl_r[i][B_ENABLE];
    assign comp_speed_select[i] = ctrl_r[i][B_SPEED];
    assign comp_ref_select[i]   = ctrl_r[i][B_REF_SEL];
    assign ref_source_select[i] = shared_r[RSEL_BIT];
    assign hysteresis_enable[i] = shared_r[HYS_BIT];

    // pin drive needs enable, comparator on and direction set to output
    assign comp_pin_out[i] = result[i];
    assign comp_pin_oe[i]  = ctrl_r[i][B_PIN_DRIVE]
                           & ctrl_r[i][B_ENABLE]
                           & ~pin_direction_control[i];
  end

  assign comp_channel_select_one = ctrl_r[0][B_CHAN_HI:B_CHAN_LO];
  assign comp_channel_select_two = ctrl_r[1][B_CHAN_HI:B_CHAN_LO];
  assign comp_change_flag        = flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // port read path
  comp_port_read u_port (
    .clk        (clk),
    .rst_b      (rst_b),
    .pin_level  (port_pin_level),
    .analog_sel (analog_sel_r),
    .port_value (port_value)
  );
endmodule : comp_ctrl_top
`default_nettype wire

// file: bench/comp_ctrl_assertions.sv
// port-level checks for the comparator control block
`timescale 1ns/10ps
`default_nettype none
module comp_ctrl_assertions
  import comp_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_bvalid,
  input wire logic [1:0]        pin_direction_control,
  input wire logic              timer_one_clock,
  input wire logic [1:0]        comp_enable,
  input wire logic [1:0]        comp_ref_select,
  input wire logic [1:0]        comp_channel_select_one,
  input wire logic [1:0]        ref_source_select,
  input wire logic [1:0]        hysteresis_enable,
  input wire logic [1:0]        comp_pin_out,
  input wire logic [1:0]        comp_pin_oe,
  input wire logic [1:0]        comp_change_flag,
  input wire logic              timer_one_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // read handshakes by target register
  sequence rd_ctrl_one;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CTRL_ONE;
  endsequence
  sequence rd_shared;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_SHARED;
  endsequence
  // pin driven only with comparator on and pin set as output
  a_oe_gating: assert property (
    (comp_pin_oe & ~(comp_enable & ~pin_direction_control)) == 2'b00)
    else $error("pin enabled without comparator on and pin output");
  a_tick_rise: assert property (
    timer_one_tick == (timer_one_clock && !$past(timer_one_clock)))
    else $error("timer tick not tied to timer clock rise");
  // flag 0 rises only from a result change or a software write
  a_flag_cause: assert property (
    $rose(comp_change_flag[0]) |-> s_axi_bvalid ||
      $past(comp_pin_out[0]) != $past(comp_pin_out[0], 2))
    else $error("change flag set without a result change");
  a_flag_sticky: assert property (
    $fell(comp_change_flag[0]) |-> $rose(s_axi_bvalid))
    else $error("change flag cleared without a write");
  a_mirror_read: assert property (
    rd_shared |=> s_axi_rdata[7:6] ==
      {$past(comp_pin_out[0]), $past(comp_pin_out[1])})
    else $error("mirror bits differ from results");
  a_result_read: assert property (
    rd_ctrl_one |=> s_axi_rdata[6] == $past(comp_pin_out[0]) &&
      s_axi_rdata[31:8] == 24'h00_0000)
    else $error("control read result bit wrong");
  a_ctrl_by_write: assert property (
    $changed({comp_enable, comp_ref_select, comp_channel_select_one})
      |-> $rose(s_axi_bvalid))
    else $error("control output moved without a write");
  a_shared_by_write: assert property (
    $changed({ref_source_select, hysteresis_enable}) |-> $rose(s_axi_bvalid))
    else $error("shared output moved without a write");
endmodule : comp_ctrl_assertions
////////////////////////////////////////////////////////////////////////
bind comp_ctrl_top comp_ctrl_assertions comp_ctrl_assertions_inst (
  .clk, .rst_b, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_bvalid, .pin_direction_control, .timer_one_clock,
  .comp_enable, .comp_ref_select, .comp_channel_select_one,
  .ref_source_select, .hysteresis_enable, .comp_pin_out, .comp_pin_oe,
  .comp_change_flag, .timer_one_tick);
`default_nettype wire

// file: bench/analog_side.sv
// analog pins and internal reference seen by both comparators
`timescale 1ns/10ps
`default_nettype none
module analog_side (
  input  wire logic [1:0]  comp_ref_select,
  input  wire logic [1:0]  comp_channel_select_one,
  input  wire logic [1:0]  comp_channel_select_two,
  input  wire logic [7:0]  pos_level,
  input  wire logic [7:0]  ref_level,
  input  wire logic [31:0] neg_level,
  output logic      [1:0]  comp_raw_above
);
  logic [7:0] plus_one;
  logic [7:0] plus_two;
  // reference select: internal reference, else shared positive pin
  assign plus_one = comp_ref_select[0] ? ref_level : pos_level;
  assign plus_two = comp_ref_select[1] ? ref_level : pos_level;
  // channel code n routes shared negative pin n
  assign comp_raw_above = {
    plus_two > neg_level[8*comp_channel_select_two +: 8],
    plus_one > neg_level[8*comp_channel_select_one +: 8]};
endmodule : analog_side
`default_nettype wire

// file: bench/dual_comparator_control_bench.sv
// self-checking bench for the comparator control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    tests_run++; \
    if ((gt) !== (ex)) begin \
      n_fail++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
    end \
  end
module dual_comparator_control_bench import comp_pkg::*;;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [DATA_W-1:0] rv;
  logic [3:0]        s_axi_wstrb = 4'h1;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rr, wb;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic              s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic              s_axi_rready = 1'b0, timer_one_clock = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid, timer_one_tick;
  logic [1:0]        pin_direction_control = 2'b00;
  logic [1:0]        comp_raw_above, comp_enable, comp_speed_select;
  logic [1:0]        comp_ref_select, ref_source_select, hysteresis_enable;
  logic [1:0]        comp_channel_select_one, comp_channel_select_two;
  logic [1:0]        comp_pin_out, comp_pin_oe, comp_change_flag;
  logic [7:0]        port_pin_level = 8'h00;
  logic [7:0]        pos_level = 8'h10;
  logic [7:0]        ref_level = 8'h80;
  logic [31:0]       neg_level = 32'h20E0_20E0;
  int                n_fail = 0;
  int                tests_run = 0;
  int                cycles = 0;

  comp_ctrl_top comp_ctrl_top_inst (.clk, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .comp_raw_above, .pin_direction_control, .timer_one_clock,
    .port_pin_level, .comp_enable, .comp_speed_select, .comp_ref_select,
    .comp_channel_select_one, .comp_channel_select_two, .ref_source_select,
    .hysteresis_enable, .comp_pin_out, .comp_pin_oe, .comp_change_flag,
    .timer_one_tick);
  analog_side analog_side_inst (.comp_ref_select, .comp_channel_select_one,
    .comp_channel_select_two, .pos_level, .ref_level, .neg_level,
    .comp_raw_above);

  always #5 clk = ~clk;
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // bus master: each channel held until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, done;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      wb = s_axi_bresp;
      @(posedge clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ar_hs, done;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  // let results and flags land, then look mid-cycle
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic set_pos(input logic [7:0] v);
    @(posedge clk);
    pos_level <= v;
    settle;
  endtask : set_pos
  ////////////////////////////////////////////////////////////////////////
  task automatic check_reset;
    rd(OFF_CTRL_ONE);
    `CHK("ctrl one", 32'h0000_0008, rv);
    rd(OFF_SHARED);
    `CHK("shared", 32'h0000_0000, rv);
    `CHK("speed out", 2'b11, comp_speed_select);
  endtask : check_reset
  // every mix of enable, polarity and input order, pin 0 at 0xE0
  task automatic check_polarity;
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      @(posedge clk);
      pos_level <= k[0] ? 8'hF0 : 8'h10;
      wr(OFF_CTRL_ONE, {24'h00_0000, k[2], 2'b00, k[1], 4'b1000});
      rd(OFF_CTRL_ONE);
      `CHK("result", k[2] ? k[0] ^ k[1] : k[1], rv[6]);
    end
  endtask : check_polarity
  // internal reference 0x80 against pins 0xE0, 0x20, 0xE0, 0x20
  task automatic check_routing;
    for (int c = 0; c < 4; c++) begin
      wr(OFF_CTRL_ONE, 32'h0000_008C | c);
      wr(OFF_CTRL_TWO, 32'h0000_008C | c);
      rd(OFF_SHARED);
      `CHK("mirror", {c[0], c[0]}, rv[7:6]);
      `CHK("channel two", c[1:0], comp_channel_select_two);
    end
  endtask : check_routing
  task automatic check_pin;
    wr(OFF_CTRL_ONE, 32'h0000_00A9);
    for (int d = 0; d < 2; d++) begin
      @(posedge clk);
      pin_direction_control <= {1'b0, ~d[0]};
      settle;
      `CHK("pin enable", d[0], comp_pin_oe[0]);
      `CHK("pin level", 1'b1, comp_pin_out[0]);
    end
    `CHK("no drive two", 1'b0, comp_pin_oe[1]);
    wr(OFF_CTRL_ONE, 32'h0000_0029);
    settle;
    `CHK("pin while off", 1'b0, comp_pin_oe[0]);
  endtask : check_pin
  // mismatch latch: mirror reads leave it, own register reads refresh it
  task automatic check_flags;
    set_pos(8'h10);
    wr(OFF_CTRL_ONE, 32'h0000_0089);
    wr(OFF_FLAGS, 32'h0000_0000);
    set_pos(8'hF0);
    `CHK("flag on change", 1'b1, comp_change_flag[0]);
    wr(OFF_FLAGS, 32'h0000_0000);
    rd(OFF_SHARED);
    set_pos(8'h10);
    `CHK("flag after mirror", 1'b0, comp_change_flag[0]);
    set_pos(8'hF0);
    rd(OFF_CTRL_ONE);
    wr(OFF_FLAGS, 32'h0000_0000);
    set_pos(8'h10);
    `CHK("flag after refresh", 1'b1, comp_change_flag[0]);
  endtask : check_flags
  task automatic check_sync;
    wr(OFF_SHARED, 32'h0000_002E);
    `CHK("ref source", 2'b01, ref_source_select);
    `CHK("hysteresis", 2'b11, hysteresis_enable);
    set_pos(8'hF0);
    @(posedge clk);
    // timer clock is fed straight in: never gated, never divided
    timer_one_clock <= 1'b1;
    @(negedge clk);
    `CHK("timer tick", 1'b1, timer_one_tick);
    rd(OFF_CTRL_ONE);
    `CHK("held on rise", 1'b0, rv[6]);
    @(posedge clk);
    timer_one_clock <= 1'b0;
    settle;
    rd(OFF_CTRL_ONE);
    `CHK("latched on fall", 1'b1, rv[6]);
    // back to free-running results, or later reads see a held value
    wr(OFF_SHARED, 32'h0000_0000);
  endtask : check_sync
  task automatic check_port;
    @(posedge clk);
    port_pin_level <= 8'hA5;
    wr(OFF_ANALOG_SEL, 32'h0000_000F);
    `CHK("write resp", RESP_OKAY, wb);
    rd(OFF_PORT_READ);
    `CHK("port read", 32'h0000_00A0, rv);
    wr(OFF_CTRL_ONE, 32'h0000_0040);
    rd(OFF_CTRL_ONE);
    `CHK("result read only", 32'h0000_0000, rv);
    rd(8'h20);
    `CHK("unmapped", {RESP_DECERR, 32'h0000_0000}, {rr, rv});
    wr(8'h20, 32'h0000_00FF);
    `CHK("unmapped write", RESP_DECERR, wb);
  endtask : check_port
  ////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    check_reset;
    check_polarity;
    check_routing;
    check_pin;
    check_flags;
    check_sync;
    check_port;
    finish_test;
  end
endmodule : dual_comparator_control_bench
`default_nettype wire
